// *** hw/msm_edge_detect.sv ***
/*
 * Rising and falling edge detector for a group of sensor inputs.
 * Assumes the inputs are already synchronous to the clock.
 */
`timescale 1ns/1ps
module msm_edge_detect
   import msm_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);

   logic [W-1:0] prev_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= i_level;
      end
   end

   // ****************************************************************
   // Per-bit edge decode
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         assign o_rise[g] = i_level[g] & ~prev_q[g];
         assign o_fall[g] = ~i_level[g] & prev_q[g];
      end
   endgenerate

endmodule

// *** hw/msm_pkg.sv ***
/*
 * Constants shared by the motor speed measurement timer and its helpers.
 * Assumes a single synchronous clock domain and plain control ports.
 */
package msm_pkg;

   // ****************************************************************
   // Counter and prescaler limits
   // ****************************************************************
   localparam int          CNT_W        = 16;
   localparam int          ST_W         = 4;
   localparam int          DIV_W        = 15;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [15:0] DOWN_THRESH  = 16'h5500;
   localparam logic [7:0]  LIMIT_LOW    = 8'hFF;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   localparam logic [3:0]  ST_MIN       = 4'h0;
   localparam logic [3:0]  ST_MAX       = 4'hF;
   localparam logic [3:0]  ST_ONE       = 4'h1;
   localparam logic [3:0]  ST_RESET     = 4'h0;
   localparam logic [14:0] DIV_RESET    = 15'h0000;
   localparam logic [14:0] DIV_ONE      = 15'h0001;

   // ****************************************************************
   // Sensor selection codes
   // ****************************************************************
   localparam logic [1:0]  SENS_TACHO   = 2'h0;
   localparam logic [1:0]  SENS_HALL    = 2'h1;
   localparam logic [1:0]  SENS_ENCODER = 2'h2;

   // ****************************************************************
   // Clock figures and Hall input width
   // ****************************************************************
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          HALL_W        = 3;

endpackage

// *** hw/msm_rate_divider.sv ***
/*
 * Binary prescaler: passes one source tick in every 2**ratio ticks.
 * Assumes source ticks are single-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
module msm_rate_divider
   import msm_pkg::*;
(
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_run,
   input  wire logic            i_src_tick,
   input  wire logic [ST_W-1:0] i_ratio,
   output logic                 o_tick
);

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] mask;

   // Low ratio bits of the divider must all be set for a tick to pass.
   function automatic logic [DIV_W-1:0] ratio_mask(logic [ST_W-1:0] r);
      logic [DIV_W-1:0] m;
      m = '0;
      for (int i = 0; i < DIV_W; i++) begin
         m[i] = (i < int'(r));
      end
      return m;
   endfunction

   assign mask   = ratio_mask(i_ratio);
   assign o_tick = i_run & i_src_tick & ((div_q & mask) == mask);

   // Stopping the divider while idle keeps the first period full length.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         div_q <= DIV_RESET;
      end else if (!i_run) begin
         div_q <= DIV_RESET;
      end else if (i_src_tick) begin
         div_q <= div_q + DIV_ONE;
      end
   end

endmodule

// *** hw/msm_speed_timer.sv ***
/*
 * Speed measurement timer: 16-bit auto-ranging period or pulse counter
 * with locked byte-wise capture, speed limit compare and event flags.
 * Assumes all inputs are synchronous to I_CLOCK and that software
 * access strobes are single-cycle pulses.
 */
// Functional notes
// - 16-bit counter; each capture stores the count, then clears it.
// - Encoder counting always goes up, ignoring the direction bit.
// - Captured 16-bit value held in capture high and low bytes.
// - Reading capture high freezes capture low; captures between are lost.
// - Speed error raised when counter exceeds programmed maximum.
// - Limit is compare byte as high byte with low byte fixed FFh.
// - Tacho mode captures on each active tacho edge.
// - Encoder capture on timer high read (select 1) or RTC tick (0).
// - Counter runs on peripheral clock, or encoder pulses with encoder.
// - At FFFFh prescaler goes up, counter halves, up flag set.
// - Capture below 5500h: prescaler down, counter cleared, down flag.
// - Prescaler zero is never decremented and raises no down flag.
// - Prescaler 15 at maximum: counter holds, no up flag, capture works.
// - Of the data registers, only counter bytes and prescaler update by themselves between captures.
// - Capture event sets the capture flag and its interrupt.
// - Speed error shares the emergency stop channel, separate flags.
// - Capture, prescaler change and speed error each have a mask.
// - Hall mode captures only on the expected sensor's toggle.
// - Hardware sets prescaler up/down flags; software clears them.
`timescale 1ns/1ps
module msm_speed_timer
   import msm_pkg::*;
(
   input  wire logic              I_CLOCK,
   input  wire logic              I_RST_N,
   input  wire logic              I_PERIPH_CLOCK_ENABLE,
   input  wire logic [1:0]        I_SENSOR_SELECT,
   input  wire logic              I_TACHO,
   input  wire logic              I_TACHO_FALLING,
   input  wire logic [HALL_W-1:0] I_SENSOR_INPUTS,
   input  wire logic [1:0]        I_HALL_EXPECTED,
   input  wire logic              I_ENCODER_PULSE,
   input  wire logic              I_RTC_TICK,
   input  wire logic              I_ENCODER_CAPTURE_SELECT,
   input  wire logic              I_COUNT_DIRECTION_BIT,
   input  wire logic [7:0]        I_WR_DATA,
   input  wire logic              I_WR_TIMER_HIGH,
   input  wire logic              I_WR_TIMER_LOW,
   input  wire logic              I_WR_PRESCALER,
   input  wire logic              I_WR_SPEED_LIMIT,
   input  wire logic              I_RD_TIMER_HIGH,
   input  wire logic              I_RD_CAPTURE_HIGH,
   input  wire logic              I_RD_CAPTURE_LOW,
   input  wire logic              I_CLR_CAPTURE_FLAG,
   input  wire logic              I_CLR_PRESCALER_UP_FLAG,
   input  wire logic              I_CLR_PRESCALER_DOWN_FLAG,
   input  wire logic              I_CLR_SPEED_ERROR_FLAG,
   input  wire logic              I_CLR_ESTOP_FLAG,
   input  wire logic              I_EMERGENCY_STOP_INPUT,
   input  wire logic              I_CAPTURE_MASK,
   input  wire logic              I_RATIO_CHANGE_INT_MASK,
   input  wire logic              I_SPEED_ERROR_MASK,
   input  wire logic              I_ESTOP_MASK,
   output logic [7:0]             O_TIMER_HIGH_BYTE,
   output logic [7:0]             O_TIMER_LOW_BYTE,
   output logic [7:0]             O_CAPTURE_HIGH_BYTE,
   output logic [7:0]             O_CAPTURE_LOW_BYTE,
   output logic [7:0]             O_SPEED_LIMIT_COMPARE,
   output logic [ST_W-1:0]        O_STEP_RATIO_PRESCALER,
   output logic                   O_CAPTURE_LOCKED,
   output logic                   O_COUNTER_STOPPED,
   output logic                   O_CAPTURE_FLAG,
   output logic                   O_PRESCALER_UP_FLAG,
   output logic                   O_PRESCALER_DOWN_FLAG,
   output logic                   O_SPEED_ERROR_FLAG,
   output logic                   O_ESTOP_FLAG,
   output logic                   O_CAPTURE_IRQ,
   output logic                   O_RATIO_CHANGE_IRQ,
   output logic                   O_ESTOP_CHANNEL_IRQ
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [CNT_W-1:0]  cap_q;
   logic [ST_W-1:0]   st_q, st_d;
   logic [7:0]        limit_q;
   logic              lock_q;
   logic              cap_flag_q, up_flag_q, dn_flag_q;
   logic              serr_flag_q, estop_flag_q;
   logic              cap_irq_q, ratio_irq_q, estop_irq_q;
   logic              stopped_q;
   logic              up_set, dn_set, cap_take;
   logic              is_enc, count_up, src_tick, tick, cap_evt;
   logic              tacho_edge, hall_evt, over_limit;
   logic [0:0]        tacho_rise, tacho_fall;
   logic [HALL_W-1:0] hall_rise, hall_fall, hall_tog;

   // ****************************************************************
   // Sensor event detection
   // ****************************************************************
   msm_edge_detect #(.W(1)) u_tacho_edge (
      .i_clk   (I_CLOCK),
      .i_rst_n (I_RST_N),
      .i_level (I_TACHO),
      .o_rise  (tacho_rise),
      .o_fall  (tacho_fall)
   );

   msm_edge_detect #(.W(HALL_W)) u_hall_edge (
      .i_clk   (I_CLOCK),
      .i_rst_n (I_RST_N),
      .i_level (I_SENSOR_INPUTS),
      .o_rise  (hall_rise),
      .o_fall  (hall_fall)
   );

   assign is_enc     = (I_SENSOR_SELECT == SENS_ENCODER);
   assign tacho_edge = I_TACHO_FALLING ? tacho_fall[0] : tacho_rise[0];
   assign hall_tog   = hall_rise | hall_fall;
   // Only the sensor picked by the multiplexer may trigger a capture.
   assign hall_evt   = (I_HALL_EXPECTED < 2'(HALL_W)) &&
                       hall_tog[I_HALL_EXPECTED];

   always_comb begin
      unique case (I_SENSOR_SELECT)
         SENS_TACHO:   cap_evt = tacho_edge;
         SENS_HALL:    cap_evt = hall_evt;
         SENS_ENCODER: cap_evt = I_ENCODER_CAPTURE_SELECT ?
                                 I_RD_TIMER_HIGH : I_RTC_TICK;
         default:      cap_evt = 1'b0;
      endcase
   end

   // ****************************************************************
   // Counter clock and prescaler
   // ****************************************************************
   assign src_tick = is_enc ? I_ENCODER_PULSE : 1'b1;
   assign count_up = is_enc | ~I_COUNT_DIRECTION_BIT;

   msm_rate_divider u_div (
      .i_clk      (I_CLOCK),
      .i_rst_n    (I_RST_N),
      .i_run      (I_PERIPH_CLOCK_ENABLE & ~stopped_q),
      .i_src_tick (src_tick),
      .i_ratio    (st_q),
      .o_tick     (tick)
   );

   // ****************************************************************
   // Counter next value
   // ****************************************************************
   // A capture outranks a counter tick in the same cycle, so the
   // cleared count is never lost to a late increment.
   always_comb begin
      cnt_d    = cnt_q;
      st_d     = st_q;
      up_set   = 1'b0;
      dn_set   = 1'b0;
      cap_take = 1'b0;
      if (!I_PERIPH_CLOCK_ENABLE) begin
         if (I_WR_TIMER_HIGH) begin
            cnt_d[15:8] = I_WR_DATA;
         end
         if (I_WR_TIMER_LOW) begin
            cnt_d[7:0] = I_WR_DATA;
         end
         if (I_WR_PRESCALER) begin
            st_d = I_WR_DATA[ST_W-1:0];
         end
      end else if (cap_evt && !lock_q) begin
         cap_take = 1'b1;
         if (cnt_q < DOWN_THRESH && st_q != ST_MIN) begin
            st_d   = st_q - ST_ONE;
            dn_set = 1'b1;
         end
         cnt_d = CNT_RESET;
      end else if (tick) begin
         if (count_up) begin
            if (cnt_q != CNT_MAX) begin
               cnt_d = cnt_q + CNT_ONE;
            end else if (st_q != ST_MAX) begin
               st_d   = st_q + ST_ONE;
               cnt_d  = {1'b0, cnt_q[15:1]};
               up_set = 1'b1;
            end
         end else if (cnt_q != CNT_RESET) begin
            cnt_d = cnt_q - CNT_ONE;
         end
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         cnt_q <= CNT_RESET;
         st_q  <= ST_RESET;
      end else begin
         cnt_q <= cnt_d;
         st_q  <= st_d;
      end
   end

   // Saturated at the top prescaler: the counter clock is held off.
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         stopped_q <= 1'b0;
      end else begin
         stopped_q <= (st_d == ST_MAX) && (cnt_d == CNT_MAX);
      end
   end

   // ****************************************************************
   // Capture register and read lock
   // ****************************************************************
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         cap_q <= CNT_RESET;
      end else if (cap_take) begin
         cap_q <= cnt_q;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         lock_q <= 1'b0;
      end else if (I_RD_CAPTURE_LOW) begin
         lock_q <= 1'b0;
      end else if (I_RD_CAPTURE_HIGH) begin
         lock_q <= 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         limit_q <= BYTE_RESET;
      end else if (I_WR_SPEED_LIMIT) begin
         limit_q <= I_WR_DATA;
      end
   end

   // ****************************************************************
   // Event flags and interrupt lines
   // ****************************************************************
   assign over_limit = cnt_q > {limit_q, LIMIT_LOW};

   // A set in the same cycle as a clear wins, so no event is dropped.
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         cap_flag_q   <= 1'b0;
         up_flag_q    <= 1'b0;
         dn_flag_q    <= 1'b0;
         serr_flag_q  <= 1'b0;
         estop_flag_q <= 1'b0;
      end else begin
         cap_flag_q   <= cap_take | (cap_flag_q & ~I_CLR_CAPTURE_FLAG);
         up_flag_q    <= up_set | (up_flag_q & ~I_CLR_PRESCALER_UP_FLAG);
         dn_flag_q    <= dn_set |
                         (dn_flag_q & ~I_CLR_PRESCALER_DOWN_FLAG);
         serr_flag_q  <= (I_PERIPH_CLOCK_ENABLE & over_limit) |
                         (serr_flag_q & ~I_CLR_SPEED_ERROR_FLAG);
         estop_flag_q <= I_EMERGENCY_STOP_INPUT |
                         (estop_flag_q & ~I_CLR_ESTOP_FLAG);
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         cap_irq_q   <= 1'b0;
         ratio_irq_q <= 1'b0;
         estop_irq_q <= 1'b0;
      end else begin
         cap_irq_q   <= cap_flag_q & I_CAPTURE_MASK;
         ratio_irq_q <= (up_flag_q | dn_flag_q) &
                        I_RATIO_CHANGE_INT_MASK;
         estop_irq_q <= (serr_flag_q & I_SPEED_ERROR_MASK) |
                        (estop_flag_q & I_ESTOP_MASK);
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign O_TIMER_HIGH_BYTE      = cnt_q[15:8];
   assign O_TIMER_LOW_BYTE       = cnt_q[7:0];
   assign O_CAPTURE_HIGH_BYTE    = cap_q[15:8];
   assign O_CAPTURE_LOW_BYTE     = cap_q[7:0];
   assign O_SPEED_LIMIT_COMPARE  = limit_q;
   assign O_STEP_RATIO_PRESCALER = st_q;
   assign O_CAPTURE_LOCKED       = lock_q;
   assign O_COUNTER_STOPPED      = stopped_q;
   assign O_CAPTURE_FLAG         = cap_flag_q;
   assign O_PRESCALER_UP_FLAG    = up_flag_q;
   assign O_PRESCALER_DOWN_FLAG  = dn_flag_q;
   assign O_SPEED_ERROR_FLAG     = serr_flag_q;
   assign O_ESTOP_FLAG           = estop_flag_q;
   assign O_CAPTURE_IRQ          = cap_irq_q;
   assign O_RATIO_CHANGE_IRQ     = ratio_irq_q;
   assign O_ESTOP_CHANNEL_IRQ    = estop_irq_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);

   capture_clears_a: assert property (
      cap_take |=> (cnt_q == CNT_RESET) && (cap_q == $past(cnt_q)))
      else $error("capture did not store and clear the counter");

   encoder_counts_up_a: assert property (
      is_enc && I_PERIPH_CLOCK_ENABLE && tick && !cap_evt &&
      cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + CNT_ONE)
      else $error("encoder count did not go up by one");

   locked_capture_a: assert property (
      lock_q && !I_RD_CAPTURE_LOW |=> $stable(cap_q))
      else $error("capture changed while the low byte was locked");

   speed_limit_a: assert property (
      I_PERIPH_CLOCK_ENABLE && cnt_q[15:8] > limit_q |=> serr_flag_q)
      else $error("speed error missed above the limit");

   prescaler_up_a: assert property (
      up_set |=> up_flag_q && st_q == $past(st_q) + ST_ONE &&
      cnt_q == {1'b0, $past(cnt_q[15:1])})
      else $error("range up step was wrong");

   prescaler_down_a: assert property (
      I_PERIPH_CLOCK_ENABLE && cap_evt && !lock_q &&
      cnt_q < DOWN_THRESH && st_q != ST_MIN
      |=> dn_flag_q && st_q == $past(st_q) - ST_ONE)
      else $error("range down step was missed");

   floor_hold_a: assert property (
      I_PERIPH_CLOCK_ENABLE && st_q == ST_MIN && !up_set
      |=> st_q == ST_MIN && !$rose(dn_flag_q))
      else $error("prescaler went below zero");

   saturate_hold_a: assert property (
      stopped_q && I_PERIPH_CLOCK_ENABLE && !cap_take
      |=> cnt_q == CNT_MAX && st_q == ST_MAX && !$rose(up_flag_q))
      else $error("saturated counter moved");

   capture_irq_a: assert property (
      cap_take |=> ##1 cap_irq_q == $past(I_CAPTURE_MASK))
      else $error("capture interrupt missing");

   estop_channel_a: assert property (
      serr_flag_q && I_SPEED_ERROR_MASK |=> estop_irq_q)
      else $error("speed error not on emergency channel");

endmodule

// *** sim/msm_sensor_model.sv ***
/*
 * Sensor side model: tachogenerator, three Hall inputs, encoder clock.
 * Assumes the bench calls its tasks; all levels change 1 ns after edge.
 */
`timescale 1ns/1ps
module msm_sensor_model (
   input  wire logic       i_clk,
   output logic            o_tacho,
   output logic [2:0]      o_hall,
   output logic            o_enc
);
   initial begin
      o_tacho = 1'b0;
      o_hall  = 3'h0;
      o_enc   = 1'b0;
   end

   task automatic step();
      @(posedge i_clk);
      #1;
   endtask

   // One full tacho period of p cycles, rising edge first.
   task automatic tacho_cycle(input int p);
      step();
      o_tacho = 1'b1;
      repeat (p / 2) step();
      o_tacho = 1'b0;
      repeat (p - p / 2 - 1) step();
   endtask

   task automatic hall_toggle(input int i);
      step();
      o_hall[i] = ~o_hall[i];
   endtask

   // Encoder pulses are spaced so that no two fall on adjacent edges.
   task automatic enc_burst(input int n);
      repeat (n) begin
         step();
         o_enc = 1'b1;
         step();
         o_enc = 1'b0;
      end
   endtask
endmodule

// *** sim/msm_speed_timer_bench.sv ***
/*
 * Self-checking bench for the speed measurement timer.
 * Assumes the sensor model and the design files are compiled first.
 */
`timescale 1ns/1ps
module msm_speed_timer_bench
   import msm_pkg::*;
;
   logic        clk, rst_n, en, dir, ecs, estop, tacho, enc;
   logic [1:0]  sel, hall_exp;
   logic [2:0]  hall;
   logic [7:0]  wdata, th, tl, ch, cl, l, lim;
   logic        tfall, lk;
   logic [12:0] str;
   logic [3:0]  ps, msk;
   logic        stopped, f_cap, f_up, f_dn, f_se, f_es, q_cap, q_rc, q_es;
   logic [31:0] rnd;
   logic [15:0] v, p;
   int          err_count, checks;

   // ****************************************************************
   // Instances
   // ****************************************************************
   msm_sensor_model i_sensor (.i_clk(clk), .o_tacho(tacho),
      .o_hall(hall), .o_enc(enc));

   msm_speed_timer i_dut (
      .I_CLOCK(clk), .I_RST_N(rst_n), .I_PERIPH_CLOCK_ENABLE(en),
      .I_SENSOR_SELECT(sel), .I_TACHO(tacho), .I_TACHO_FALLING(tfall),
      .I_SENSOR_INPUTS(hall), .I_HALL_EXPECTED(hall_exp),
      .I_ENCODER_PULSE(enc), .I_RTC_TICK(str[12]),
      .I_ENCODER_CAPTURE_SELECT(ecs), .I_COUNT_DIRECTION_BIT(dir),
      .I_WR_DATA(wdata), .I_WR_TIMER_HIGH(str[0]),
      .I_WR_TIMER_LOW(str[1]), .I_WR_PRESCALER(str[2]),
      .I_WR_SPEED_LIMIT(str[3]), .I_RD_TIMER_HIGH(str[4]),
      .I_RD_CAPTURE_HIGH(str[5]), .I_RD_CAPTURE_LOW(str[6]),
      .I_CLR_CAPTURE_FLAG(str[7]), .I_CLR_PRESCALER_UP_FLAG(str[8]),
      .I_CLR_PRESCALER_DOWN_FLAG(str[9]), .I_CLR_SPEED_ERROR_FLAG(str[10]),
      .I_CLR_ESTOP_FLAG(str[11]), .I_EMERGENCY_STOP_INPUT(estop),
      .I_CAPTURE_MASK(msk[0]), .I_RATIO_CHANGE_INT_MASK(msk[1]),
      .I_SPEED_ERROR_MASK(msk[2]), .I_ESTOP_MASK(msk[3]),
      .O_TIMER_HIGH_BYTE(th), .O_TIMER_LOW_BYTE(tl),
      .O_CAPTURE_HIGH_BYTE(ch), .O_CAPTURE_LOW_BYTE(cl),
      .O_SPEED_LIMIT_COMPARE(lim), .O_STEP_RATIO_PRESCALER(ps),
      .O_CAPTURE_LOCKED(lk), .O_COUNTER_STOPPED(stopped),
      .O_CAPTURE_FLAG(f_cap), .O_PRESCALER_UP_FLAG(f_up),
      .O_PRESCALER_DOWN_FLAG(f_dn), .O_SPEED_ERROR_FLAG(f_se),
      .O_ESTOP_FLAG(f_es), .O_CAPTURE_IRQ(q_cap),
      .O_RATIO_CHANGE_IRQ(q_rc), .O_ESTOP_CHANNEL_IRQ(q_es));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] limit_word(input logic [7:0] b);
      return {b, 8'hFF};
   endfunction

   // A period capture may land up to two counts below or one count above the nominal count.
   function automatic logic cap_ok(input logic [15:0] c, input logic [15:0] n);
      return (c + 16'h0002 >= n) && (c <= n + 16'h0001);
   endfunction

   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input int b, input logic [7:0] d);
      wdata = d;
      str[b] = 1'b1;
      step();
      str[b] = 1'b0;
   endtask

   // Counter and prescaler only accept writes with the clock stopped.
   task automatic cfg(input logic [3:0] s, input logic [15:0] t,
                      input logic [1:0] m);
      en = 1'b0;
      str[11:7] = 5'h1F;
      wr(2, {4'h0, s});
      str[11:7] = 5'h00;
      wr(0, t[15:8]);
      wr(1, t[7:0]);
      sel = m;
      en = 1'b1;
   endtask

   task automatic complete_run();
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The sequence needs about six hundred cycles; over thirty times that is a hang.
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      rst_n = 1'b0; en = 1'b0; dir = 1'b0; ecs = 1'b0; estop = 1'b0;
      sel = SENS_TACHO; hall_exp = 2'h1; wdata = 8'h00; str = 13'h0000;
      rnd = 32'h5665; err_count = 0; checks = 0; l = 8'h00;
      tfall = 1'b0;
      msk = 4'hF;
      step(5);
      rst_n = 1'b1;
      step();
      chk({th, tl}, CNT_RESET);
      chk({ch, cl}, CNT_RESET);
      rnd = lfsr(rnd);
      p = 16'(20 + int'(rnd[5:0]));
      cfg(4'h0, 16'h0000, SENS_TACHO);
      repeat (2) i_sensor.tacho_cycle(int'(p));
      v = {ch, cl};
      i_sensor.tacho_cycle(int'(p));
      chk({ch, cl}, v);
      chk(16'(cap_ok(v, p)), 16'h0001);
      chk({12'h000, ps}, 16'h0000);
      chk(16'(f_dn), 16'h0000);
      chk(16'(q_cap), 16'h0001);
      msk = 4'hE;
      step(2);
      chk(16'(q_cap), 16'h0000);
      msk = 4'hF;
      wr(2, 8'h05);
      chk({12'h000, ps}, 16'h0000);
      wr(5, 8'h00);
      chk(16'(lk), 16'h0001);
      v = {ch, cl};
      wr(7, 8'h00);
      repeat (2) i_sensor.tacho_cycle(int'(p) + 7);
      chk({ch, cl}, v);
      chk(16'(f_cap), 16'h0000);
      wr(6, 8'h00);
      chk(16'(lk), 16'h0000);
      i_sensor.tacho_cycle(int'(p));
      chk(16'(f_cap), 16'h0001);
      cfg(4'h2, 16'h0000, SENS_TACHO);
      i_sensor.tacho_cycle(40);
      chk({12'h000, ps}, 16'h0001);
      chk(16'(f_dn), 16'h0001);
      chk(16'(q_rc), 16'h0001);
      wr(9, 8'h00);
      chk(16'(f_dn), 16'h0000);
      i_sensor.tacho_cycle(40);
      wr(9, 8'h00);
      i_sensor.tacho_cycle(40);
      chk({12'h000, ps}, 16'h0000);
      chk(16'(f_dn), 16'h0000);
      tfall = 1'b1;
      cfg(4'h0, 16'h0000, SENS_TACHO);
      i_sensor.tacho_cycle(40);
      chk(16'(cap_ok({ch, cl}, 16'h0015)), 16'h0001);
      tfall = 1'b0;
      cfg(4'h0, 16'h0000, SENS_HALL);
      i_sensor.hall_toggle(0);
      step(3);
      chk(16'(f_cap), 16'h0000);
      i_sensor.hall_toggle(1);
      step(3);
      chk(16'(f_cap), 16'h0001);
      rnd = lfsr(rnd);
      dir = 1'b1;
      ecs = 1'b1;
      cfg(4'h0, 16'h0000, SENS_ENCODER);
      i_sensor.enc_burst(int'(rnd[5:0]) + 1);
      step(2);
      chk({th, tl}, 16'(rnd[5:0]) + 16'h0001);
      wr(4, 8'h00);
      step(3);
      chk({ch, cl}, 16'(rnd[5:0]) + 16'h0001);
      ecs = 1'b0;
      i_sensor.enc_burst(int'(rnd[13:8]) + 3);
      step(2);
      wr(12, 8'h00);
      step(3);
      chk({ch, cl}, 16'(rnd[13:8]) + 16'h0003);
      dir = 1'b0;
      l = {1'b0, rnd[22:16]};
      wr(3, l);
      chk({8'h00, lim}, {8'h00, l});
      cfg(4'h0, {l, 8'hFE}, 2'h3);
      for (int i = 0; i < 8 && {th, tl} !== limit_word(l); i++) step();
      chk(16'(f_se), 16'h0000);
      step(2);
      chk(16'(f_se), 16'h0001);
      step();
      chk(16'(q_es), 16'h0001);
      chk(16'(f_es), 16'h0000);
      estop = 1'b1;
      step();
      estop = 1'b0;
      step();
      chk(16'(f_es), 16'h0001);
      rnd = lfsr(rnd);
      msk = rnd[3:0];
      step(2);
      chk(16'(q_es), 16'(msk[2] | msk[3]));
      msk = 4'hF;
      cfg(4'h0, 16'hFFFD, 2'h3);
      for (int i = 0; i < 8 && ps !== 4'h1; i++) step();
      chk({8'h00, th}, 16'h007F);
      chk(16'(f_up), 16'h0001);
      step();
      chk(16'(q_rc), 16'h0001);
      cfg(4'hF, 16'hFFFF, 2'h3);
      step(4);
      chk({th, tl}, CNT_MAX);
      chk(16'(stopped), 16'h0001);
      chk(16'(f_up), 16'h0000);
      sel = SENS_TACHO;
      i_sensor.tacho_cycle(10);
      chk({ch, cl}, CNT_MAX);
      chk({12'h000, ps}, 16'h000F);
      complete_run();
   end
endmodule
